//--- pkg/csso_pkg.sv
package csso_pkg;

  // opcodes
  localparam logic [7:0] OPC_CARRY_SET = 8'hDF;
  localparam logic [7:0] OPC_SHIFT_R = 8'hD0;
  localparam logic [7:0] OPC_SHIFT_IR = 8'hD1;
  localparam logic [7:0] OPC_PTR_LOAD = 8'h31;
  localparam logic [7:0] OPC_STOP = 8'h7F;
  localparam logic [7:0] OPC_SUB_RR_W = 8'h22;
  localparam logic [7:0] OPC_SUB_RIR_W = 8'h23;
  localparam logic [7:0] OPC_SUB_RR = 8'h24;
  localparam logic [7:0] OPC_SUB_RIR = 8'h25;
  localparam logic [7:0] OPC_SUB_IM = 8'h26;

  // execution cycle counts
  localparam int CYC_SHORT = 4;
  localparam int CYC_LONG = 6;
  localparam int CNT_W = 3;

  // status flag bit positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;

  // pointer-load selector codes in immediate bits 1:0
  localparam logic [1:0] SEL_PTR_ZERO = 2'h2;
  localparam logic [1:0] SEL_PTR_ONE = 2'h1;
  localparam logic [1:0] SEL_PTR_BOTH = 2'h0;
  localparam int PTR_BIT3 = 3;

  // register map, byte addresses
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_PTR = 8'h0C;
  localparam logic [7:0] ADDR_RADDR = 8'h10;
  localparam logic [7:0] ADDR_RDATA = 8'h14;

  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_STOP = 1;
  localparam int STAT_BAD_OP = 2;

  // reset values
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_PTR0 = 8'hC0;
  localparam logic [7:0] RST_PTR1 = 8'hC8;

  typedef enum logic [2:0] {
    ALU_NONE = 3'b000,
    ALU_CARRY_SET = 3'b001,
    ALU_SHIFT = 3'b010,
    ALU_SUB = 3'b011,
    ALU_PTR = 3'b100
  } csso_alu_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_STOP = 2'b10
  } csso_state_type;

endpackage : csso_pkg

//--- logic/csso_alu.sv
`timescale 1ns/1ns
module csso_alu
  import csso_pkg::*;
(
  input wire csso_alu_op_type op,
  input wire logic [7:0] dst,
  input wire logic [7:0] src,
  input wire logic [7:0] flags_in,
  input wire logic [7:0] ptr0_in,
  input wire logic [7:0] ptr1_in,
  output logic [7:0] result,
  output logic result_we,
  output logic [7:0] flags_out,
  output logic [7:0] ptr0_out,
  output logic [7:0] ptr1_out
);

  logic [8:0] diff;
  logic [4:0] low_sum;

  // subtraction as dst plus two's complement of src
  assign diff = {1'b0, dst} + {1'b0, ~src} + 9'h001;
  assign low_sum = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + 5'h01;

  always_comb begin
    result = dst;
    result_we = 1'b0;
    flags_out = flags_in;
    ptr0_out = ptr0_in;
    ptr1_out = ptr1_in;
    unique case (op)
      ALU_CARRY_SET: begin
        flags_out[FLAG_C] = 1'b1;
      end
      ALU_SHIFT: begin
        result = {dst[7], dst[7:1]};
        result_we = 1'b1;
        flags_out[FLAG_C] = dst[0];
        flags_out[FLAG_Z] = ({dst[7], dst[7:1]} == 8'h00);
        flags_out[FLAG_S] = dst[7];
        flags_out[FLAG_V] = 1'b0;
      end
      ALU_SUB: begin
        result = diff[7:0];
        result_we = 1'b1;
        flags_out[FLAG_C] = ~diff[8];
        flags_out[FLAG_Z] = (diff[7:0] == 8'h00);
        flags_out[FLAG_S] = diff[7];
        flags_out[FLAG_V] = (dst[7] != src[7]) && (diff[7] == src[7]);
        flags_out[FLAG_D] = 1'b1;
        flags_out[FLAG_H] = ~low_sum[4];
      end
      ALU_PTR: begin
        // other selector code writes nothing
        unique case (src[1:0])
          SEL_PTR_ZERO: ptr0_out[7:3] = src[7:3];
          SEL_PTR_ONE: ptr1_out[7:3] = src[7:3];
          SEL_PTR_BOTH: begin
            ptr0_out = {src[7:4], 1'b0, ptr0_in[2:0]};
            ptr1_out = {src[7:4], 1'b1, ptr1_in[2:0]};
          end
          default: begin
          end
        endcase
      end
      default: begin
      end
    endcase
  end

endmodule : csso_alu

//--- logic/csso_core.sv
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module csso_core
  import csso_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic ext_int_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic stop_mode,
  output logic cpu_clk_en
);

  logic [7:0] reg_file [0:255];

  csso_state_type state;
  logic [CNT_W-1:0] cycle_cnt;
  logic [23:0] instr;
  logic bad_op;
  logic [7:0] flags;
  logic [7:0] ptr0;
  logic [7:0] ptr1;
  logic [7:0] reg_addr;

  // latched operation, applied when the cycle count runs out
  csso_alu_op_type pend_op;
  logic pend_stop;
  logic pend_we;
  logic [7:0] pend_addr;
  logic [7:0] pend_result;
  logic [7:0] pend_flags;
  logic [7:0] pend_ptr0;
  logic [7:0] pend_ptr1;

  logic setup;
  logic wr_fire;
  logic idle_wr;
  logic issue;
  logic commit;
  logic [7:0] opc;
  logic [7:0] op_b1;
  logic [7:0] op_b2;
  csso_alu_op_type dec_op;
  logic [CNT_W-1:0] dec_cnt;
  logic dec_legal;
  logic [7:0] dst_addr;
  logic [7:0] src_val;
  logic [7:0] alu_result;
  logic alu_we;
  logic [7:0] alu_flags;
  logic [7:0] alu_ptr0;
  logic [7:0] alu_ptr1;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // working register n maps through pointer zero for r0..r7, pointer one for r8..r15
  function automatic logic [7:0] work_addr(input logic [3:0] n, input logic [7:0] p0, input logic [7:0] p1);
    logic [7:0] base;
    base = n[3] ? p1 : p0;
    work_addr = {base[7:3], n[2:0]};
  endfunction : work_addr

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
    addr_is = (a == target);
  endfunction : addr_is

  function automatic logic [CNT_W-1:0] cnt_of(input int cycles);
    cnt_of = CNT_W'(cycles - 1);
  endfunction : cnt_of

  assign setup = psel && !penable;
  assign wr_fire = psel && penable && pready && pwrite;
  // state writes are refused while executing or stopped so nothing alters retained state
  assign idle_wr = wr_fire && (state == ST_IDLE);
  assign opc = pwdata[7:0];
  assign op_b1 = pwdata[15:8];
  assign op_b2 = pwdata[23:16];
  assign issue = idle_wr && addr_is(paddr, ADDR_INSTR);
  assign commit = (state == ST_EXEC) && (cycle_cnt == '0);

  // opcode decode: operation class and cycle count
  always_comb begin
    dec_op = ALU_NONE;
    dec_cnt = cnt_of(CYC_SHORT);
    dec_legal = 1'b1;
    unique case (opc)
      OPC_CARRY_SET: dec_op = ALU_CARRY_SET;
      OPC_SHIFT_R, OPC_SHIFT_IR: dec_op = ALU_SHIFT;
      OPC_PTR_LOAD: dec_op = ALU_PTR;
      OPC_STOP: dec_op = ALU_NONE;
      OPC_SUB_RR_W: dec_op = ALU_SUB;
      OPC_SUB_RIR_W, OPC_SUB_RR, OPC_SUB_RIR, OPC_SUB_IM: begin
        dec_op = ALU_SUB;
        dec_cnt = cnt_of(CYC_LONG);
      end
      default: dec_legal = 1'b0;
    endcase
  end

  // operand addressing
  always_comb begin
    dst_addr = op_b1;
    src_val = 8'h00;
    unique case (opc)
      OPC_SHIFT_IR: dst_addr = reg_file[op_b1];
      OPC_SUB_RR_W: begin
        dst_addr = work_addr(op_b1[7:4], ptr0, ptr1);
        src_val = reg_file[work_addr(op_b1[3:0], ptr0, ptr1)];
      end
      OPC_SUB_RIR_W: begin
        dst_addr = work_addr(op_b1[7:4], ptr0, ptr1);
        src_val = reg_file[reg_file[work_addr(op_b1[3:0], ptr0, ptr1)]];
      end
      OPC_SUB_RR: begin
        dst_addr = op_b2;
        src_val = reg_file[op_b1];
      end
      OPC_SUB_RIR: begin
        dst_addr = op_b2;
        src_val = reg_file[reg_file[op_b1]];
      end
      OPC_SUB_IM: begin
        dst_addr = op_b1;
        src_val = op_b2;
      end
      OPC_PTR_LOAD: src_val = op_b1;
      default: begin
      end
    endcase
  end

  csso_alu u_alu (
    .op(dec_op),
    .dst(reg_file[dst_addr]),
    .src(src_val),
    .flags_in(flags),
    .ptr0_in(ptr0),
    .ptr1_in(ptr1),
    .result(alu_result),
    .result_we(alu_we),
    .flags_out(alu_flags),
    .ptr0_out(alu_ptr0),
    .ptr1_out(alu_ptr1)
  );

  // execution sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cycle_cnt <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (issue && dec_legal) begin
            state <= ST_EXEC;
            cycle_cnt <= dec_cnt;
          end
        end
        ST_EXEC: begin
          if (commit) begin
            state <= pend_stop ? ST_STOP : ST_IDLE;
          end else begin
            cycle_cnt <= cycle_cnt - 1'b1;
          end
        end
        ST_STOP: begin
          // the CPU clock enable is off, so besides reset only the external request pin can wake us
          if (ext_int_req) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // operation latched at issue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_op <= ALU_NONE;
      pend_stop <= 1'b0;
      pend_we <= 1'b0;
      pend_addr <= 8'h00;
      pend_result <= 8'h00;
      pend_flags <= RST_FLAGS;
      pend_ptr0 <= RST_PTR0;
      pend_ptr1 <= RST_PTR1;
    end else if (issue && dec_legal) begin
      pend_op <= dec_op;
      pend_stop <= (opc == OPC_STOP);
      pend_we <= alu_we;
      pend_addr <= dst_addr;
      pend_result <= alu_result;
      pend_flags <= alu_flags;
      pend_ptr0 <= alu_ptr0;
      pend_ptr1 <= alu_ptr1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr <= 24'h000000;
      bad_op <= 1'b0;
    end else if (issue) begin
      instr <= pwdata[23:0];
      bad_op <= !dec_legal;
    end
  end

  // status flags: stop and pointer load leave them alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= RST_FLAGS;
    end else if (commit && pend_op != ALU_NONE && pend_op != ALU_PTR) begin
      flags <= pend_flags;
    end else if (idle_wr && addr_is(paddr, ADDR_FLAGS)) begin
      flags <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr0 <= RST_PTR0;
      ptr1 <= RST_PTR1;
    end else if (commit && pend_op == ALU_PTR) begin
      ptr0 <= pend_ptr0;
      ptr1 <= pend_ptr1;
    end else if (idle_wr && addr_is(paddr, ADDR_PTR)) begin
      ptr0 <= pwdata[7:0];
      ptr1 <= pwdata[15:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_addr <= 8'h00;
    end else if (idle_wr && addr_is(paddr, ADDR_RADDR)) begin
      reg_addr <= pwdata[7:0];
    end
  end

  // register file: data memory, not reset; retained through stop
  always_ff @(posedge pclk) begin
    if (commit && pend_we) begin
      reg_file[pend_addr] <= pend_result;
    end else if (idle_wr && addr_is(paddr, ADDR_RDATA)) begin
      reg_file[reg_addr] <= pwdata[7:0];
    end
  end

  // clock gating indication for the rest of the chip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_mode <= 1'b0;
      cpu_clk_en <= 1'b1;
    end else begin
      stop_mode <= (state == ST_EXEC && commit && pend_stop) || (state == ST_STOP && !ext_int_req);
      cpu_clk_en <= !((state == ST_EXEC && commit && pend_stop) || (state == ST_STOP && !ext_int_req));
    end
  end

  // apb read mux, sampled in the setup cycle
  always_comb begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    if (addr_is(paddr, ADDR_INSTR)) begin
      next_prdata = {8'h00, instr};
    end else if (addr_is(paddr, ADDR_STATUS)) begin
      next_prdata[STAT_BUSY] = (state == ST_EXEC);
      next_prdata[STAT_STOP] = (state == ST_STOP);
      next_prdata[STAT_BAD_OP] = bad_op;
    end else if (addr_is(paddr, ADDR_FLAGS)) begin
      next_prdata = {24'h000000, flags};
    end else if (addr_is(paddr, ADDR_PTR)) begin
      next_prdata = {16'h0000, ptr1, ptr0};
    end else if (addr_is(paddr, ADDR_RADDR)) begin
      next_prdata = {24'h000000, reg_addr};
    end else if (addr_is(paddr, ADDR_RDATA)) begin
      next_prdata = {24'h000000, reg_file[reg_addr]};
    end else begin
      next_pslverr = 1'b1;
    end
  end

  // one wait-free access phase: ready rises the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= next_pslverr;
        prdata <= pwrite ? 32'h00000000 : next_prdata;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule : csso_core

//--- verification/csso_chk.sv
`timescale 1ns/1ns
module csso_chk
  import csso_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic ext_int_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_mode,
  input wire logic cpu_clk_en
);
  logic stop_wr;
  assign stop_wr = psel && penable && pready && pwrite && paddr == ADDR_INSTR && pwdata[7:0] == OPC_STOP;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_one_beat;
    pready ##1 !pready;
  endsequence
  property p_ready;
    s_setup |=> s_one_beat;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not one beat after setup");
  property p_unmapped;
    s_setup and paddr[7:2] > ADDR_RDATA[7:2] |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_err_beat;
    pslverr |-> pready;
  endproperty
  a_err_beat: assert property (p_err_beat) else $error("error without ready");
  property p_wr_zero;
    pready && pwrite |-> prdata == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data on a write");
  property p_clk_en;
    cpu_clk_en != stop_mode;
  endproperty
  a_clk_en: assert property (p_clk_en) else $error("clock enable not inverse of stop");
  // five edges: four execution cycles plus the registered stop flag
  property p_stop_entry;
    $rose(stop_mode) |-> $past(stop_wr, 5);
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop without stop opcode");
  property p_retain;
    stop_mode && !ext_int_req |=> stop_mode;
  endproperty
  a_retain: assert property (p_retain) else $error("stop left without wake source");
  property p_wake;
    stop_mode && ext_int_req |=> !stop_mode;
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not wake");
  property p_fall_cause;
    $fell(stop_mode) |-> $past(ext_int_req);
  endproperty
  a_fall_cause: assert property (p_fall_cause) else $error("stop dropped without interrupt");
endmodule : csso_chk

//--- verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  import csso_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, ext_int_req, pready, pslverr, stop_mode, cpu_clk_en;
  logic [7:0] paddr, fl, d, s, r, im, p0, p1, da, sa, t;
  logic [31:0] pwdata, prdata, rs;
  logic [23:0] ins;
  logic [15:0] ex;
  logic [32:0] exp_q[$];
  int err_total, checked, cyc, op;
  localparam logic [7:0] SUBOP [5] = '{OPC_SUB_RR_W, OPC_SUB_RIR_W, OPC_SUB_RR, OPC_SUB_RIR, OPC_SUB_IM};
  csso_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .ext_int_req(ext_int_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_mode(stop_mode), .cpu_clk_en(cpu_clk_en));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction : rnd
  // flags above the result byte, as the flag register packs them
  function automatic logic [15:0] subx(input logic [7:0] a, input logic [7:0] b, input logic [7:0] f);
    logic [7:0] q;
    logic [4:0] h;
    q = a - b;
    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h1;
    return {b > a, q == 8'h0, q[7], (a[7] != b[7]) && (q[7] == b[7]), 1'b1, !h[4], f[1:0], q};
  endfunction : subx
  task automatic chk(input string n, input logic [32:0] seen, input logic [32:0] e);
    checked++;
    if (seen !== e) begin
      err_total++;
      $display("BAD %s exp %h seen %h", n, e, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, 33'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd
  task automatic setr(input logic [7:0] a, input logic [7:0] v);
    wr(ADDR_RADDR, {24'h0, a});
    wr(ADDR_RDATA, {24'h0, v});
  endtask : setr
  task automatic getr(input logic [7:0] a, input logic [7:0] e);
    wr(ADDR_RADDR, {24'h0, a});
    rd(ADDR_RDATA, {24'h0, e});
  endtask : getr
  // second status read lands after a four-cycle op commits but before a six-cycle one
  task automatic issue(input logic [23:0] i, input logic [31:0] st, input logic six);
    wr(ADDR_INSTR, {8'h0, i});
    rd(ADDR_STATUS, 32'h1);
    rd(ADDR_STATUS, six ? 32'h1 : st);
    if (six) rd(ADDR_STATUS, st);
  endtask : issue
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected beat", 33'h0, 33'h1);
      else chk("apb", {pslverr, prdata}, exp_q.pop_front());
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    rs = 32'h951B;
    {psel, penable, pwrite, ext_int_req, presetn} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_FLAGS, {24'h0, RST_FLAGS});
    rd(ADDR_PTR, {16'h0, RST_PTR1, RST_PTR0});
    apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h40, 32'h5, {1'b1, 32'h0});
    wr(ADDR_INSTR, 32'h55);
    rd(ADDR_STATUS, 32'h4);
    for (int k = 0; k < 2; k++) begin
      t = rnd();
      fl = {k[0], t[6:0]};
      wr(ADDR_FLAGS, {24'h0, fl});
      issue({16'h0, OPC_CARRY_SET}, 32'h0, 1'b0);
      rd(ADDR_FLAGS, {24'h0, 1'b1, fl[6:0]});
    end
    for (int k = 0; k < 6; k++) begin
      fl = rnd();
      d = (k == 0) ? 8'h01 : rnd();
      r = {d[7], d[7:1]};
      da = k[0] ? 8'h30 : 8'h20;
      wr(ADDR_FLAGS, {24'h0, fl});
      setr(8'h21, 8'h30);
      setr(da, d);
      issue(k[0] ? {8'h0, 8'h21, OPC_SHIFT_IR} : {8'h0, 8'h20, OPC_SHIFT_R}, 32'h0, 1'b0);
      getr(da, r);
      getr(8'h21, 8'h30);
      rd(ADDR_FLAGS, {24'h0, d[0], r == 8'h0, r[7], 1'b0, fl[3:0]});
    end
    for (int k = 0; k < 4; k++) begin
      p0 = rnd();
      p1 = rnd();
      fl = rnd();
      t = rnd();
      im = {t[7:2], k[1:0]};
      wr(ADDR_PTR, {16'h0, p1, p0});
      wr(ADDR_FLAGS, {24'h0, fl});
      issue({8'h0, im, OPC_PTR_LOAD}, 32'h0, 1'b0);
      case (im[1:0])
        SEL_PTR_ZERO: p0 = {im[7:3], p0[2:0]};
        SEL_PTR_ONE: p1 = {im[7:3], p1[2:0]};
        SEL_PTR_BOTH: begin
          p0 = {im[7:4], 1'b0, p0[2:0]};
          p1 = {im[7:4], 1'b1, p1[2:0]};
        end
        default: ;
      endcase
      rd(ADDR_PTR, {16'h0, p1, p0});
      rd(ADDR_FLAGS, {24'h0, fl});
    end
    wr(ADDR_PTR, 32'h4840);
    for (int k = 0; k < 15; k++) begin
      op = k % 5;
      fl = rnd();
      d = rnd();
      s = (k == 7) ? d : rnd();
      da = op < 2 ? 8'h41 : 8'h51;
      sa = op[0] ? 8'h60 : (op == 0 ? 8'h42 : 8'h52);
      wr(ADDR_FLAGS, {24'h0, fl});
      setr(da, d);
      if (op != 4) setr(sa, s);
      if (op[0]) setr(op == 1 ? 8'h42 : 8'h52, 8'h60);
      ins = op == 4 ? {s, 8'h51, SUBOP[op]} : (op < 2 ? {8'h0, 8'h12, SUBOP[op]} : {8'h51, 8'h52, SUBOP[op]});
      issue(ins, 32'h0, op != 0);
      ex = subx(d, s, fl);
      getr(da, ex[7:0]);
      if (op != 4) getr(sa, s);
      rd(ADDR_FLAGS, {24'h0, ex[15:8]});
    end
    issue({16'h0, OPC_STOP}, 32'h2, 1'b0);
    chk("stop", {31'h0, stop_mode, cpu_clk_en}, 33'h2);
    wr(ADDR_FLAGS, 32'hFF);
    wr(ADDR_PTR, 32'h0);
    rd(ADDR_FLAGS, {24'h0, ex[15:8]});
    rd(ADDR_PTR, 32'h4840);
    repeat (20) @(posedge pclk);
    ext_int_req <= 1'b1;
    @(posedge pclk);
    chk("stop held", {32'h0, stop_mode}, 33'h1);
    ext_int_req <= 1'b0;
    @(posedge pclk);
    chk("woken", {32'h0, stop_mode}, 33'h0);
    rd(ADDR_STATUS, 32'h0);
    issue({16'h0, OPC_STOP}, 32'h2, 1'b0);
    // reset held over two edges, standing in for oscillator settling
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset wake", {32'h0, stop_mode}, 33'h0);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_PTR, {16'h0, RST_PTR1, RST_PTR0});
    // one more edge so the monitor takes the last beat before closing
    @(posedge pclk);
    chk("pending", 33'(exp_q.size()), 33'h0);
    end_sim();
  end
endmodule : testbench
bind csso_core csso_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .ext_int_req(ext_int_req), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .stop_mode(stop_mode), .cpu_clk_en(cpu_clk_en));
